// ### sigpath_units.sv
// Digital-side mixers, attenuator, gain control, equalizer and peak monitor
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`default_nettype none
// Function
// - Three channels; simple serial mode only first
// - Channel two splits into two companded slots
// - Output sums two signals plus attenuated third
// - Optional highpass removes DC on inputs
// - Every summation input uses 5-bit select
// - Each channel has 8-bit third-input attenuation
// - Universal attenuator scales selected signal
// - Gain stage adds two, second 15-bit attenuated
// - Pre-amplifier sum exported as internal signal
// - Gain stage has its own enable bit
// - Peak tracker captures maxima, decays by a shifted fraction plus optional one
// - Regulate only above 7-bit threshold
// - Gain stage holds its programmable settings
// - Equalizer: IIR then 17-tap FIR
// - Equalizer enable and 5-bit source select
// - Coefficients reached through index and data register
// - Index advances after each data access
// - Out-of-range access resets index to zero
// - Peak monitor holds min or max since read
// - Max mode loads most negative on enable/read
module signal_path_conditioning_units (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [6:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // Sample stream, one strobe per sample period
  input wire logic sample_strobe,
  input wire logic [15:0] from_ch1,
  input wire logic [15:0] from_ch2,
  input wire logic [15:0] from_ch3,
  input wire logic [15:0] from_analog,
  // Outputs
  output logic [15:0] to_ch1,
  output logic [15:0] to_ch2,
  output logic [15:0] to_ch3,
  output logic [7:0] to_ch2_slot1,
  output logic [15:0] universal_atten_out,
  output logic [15:0] gain_stage_out,
  output logic [15:0] gain_stage_sum_out,
  output logic [15:0] equalizer_out,
  output logic out_valid
);
  typedef enum logic [1:0] {BUS_IDLE, BUS_ANSWER} bus_state_t;
  bus_state_t bus_state;
  logic [15:0] mix_sel [3];
  logic [15:0] sidetone_ch12, sidetone_ch3, univ_ctrl, agc_cfg, agc_inatt;
  logic [15:0] agc_init_cmp, agc_rates, agc_ranges, agc_peak_cfg, agc_lowpass;
  logic [15:0] eq_ctrl, peak_ctrl, link_mode, peak_value;
  localparam int unsigned EQ_COEFS_L = sigpath_pkg::EQ_COEFS;
  logic [15:0] eq_coef [EQ_COEFS_L];
  logic signed [15:0] sig [32];
  logic signed [15:0] hp_in [3], hp_prev_x [3], hp_prev_y [3];
  logic signed [15:0] agc_peak, agc_gain, eq_iir_x [9], eq_iir_y [8], eq_fir [17];
  logic peak_en_d;
  logic [31:0] next_readdata;
  logic [15:0] wdat;

  // Signed scaling by a fraction of 256 or 32768
  function automatic logic signed [15:0] scale8(input logic signed [15:0] x, input logic [7:0] a);
    logic signed [24:0] p;
    p = x * $signed({1'b0, a});
    return p[23:8];
  endfunction
  function automatic logic signed [15:0] scale15(input logic signed [15:0] x, input logic [14:0] a);
    logic signed [31:0] p;
    p = x * $signed({1'b0, a});
    return p[30:15];
  endfunction
  function automatic logic signed [15:0] sat(input logic signed [17:0] x);
    if (x > 18'sd32767)
      return 16'sh7fff;
    else if (x < -18'sd32768)
      return -16'sh8000;
    return x[15:0];
  endfunction
  // Companding to 8 bits, log of magnitude, inverted for mu-law
  function automatic logic [7:0] compand(input logic signed [15:0] x, input logic mu);
    logic [14:0] m;
    logic [2:0] e;
    logic [7:0] c;
    m = x[15] ? 15'(-x) : x[14:0];
    e = 3'd0;
    for (int i = 8; i < 15; i++)
      if (m[i])
        e = 3'(i - 7);
    c = {x[15], e, 4'(m >> (e == 3'd0 ? 4 : e + 3))};
    return mu ? ~c : (c ^ 8'h55);
  endfunction

  // Internal signal table, 5-bit selects pick from it
  wire signed [15:0] hp_out [3];
  wire signed [15:0] eq_iir_out, eq_fir_out;
  wire signed [15:0] agc_sum;
  always_comb begin
    for (int i = 0; i < 32; i++)
      sig[i] = 16'sh0000;
    sig[1] = hp_out[0];
    sig[2] = hp_out[1];
    sig[3] = hp_out[2];
    sig[4] = from_analog;
    sig[5] = to_ch1;
    sig[6] = to_ch2;
    sig[7] = to_ch3;
    sig[8] = universal_atten_out;
    sig[9] = gain_stage_out;
    sig[10] = gain_stage_sum_out;
    sig[11] = equalizer_out;
  end

  // Highpass select on each incoming channel
  assign hp_in[0] = from_ch1;
  assign hp_in[1] = link_mode[sigpath_pkg::BIT_SIMPLE] ? 16'sh0000 : from_ch2;
  assign hp_in[2] = link_mode[sigpath_pkg::BIT_SIMPLE] ? 16'sh0000 : from_ch3;
  generate
    for (genvar c = 0; c < 3; c++) begin : g_hp
      // y = x - x1 + y1*(1-1/256): first-order DC block
      wire signed [17:0] hp_y = 18'(hp_in[c]) - 18'(hp_prev_x[c]) + 18'(hp_prev_y[c])
                               - 18'(hp_prev_y[c] >>> 8);
      assign hp_out[c] = mix_sel[c][sigpath_pkg::BIT_HP] ? hp_prev_y[c] : hp_in[c];
      always_ff @(posedge clk) begin
        if (reset) begin
          hp_prev_x[c] <= 16'sh0000;
          hp_prev_y[c] <= 16'sh0000;
        end else if (sample_strobe) begin
          hp_prev_x[c] <= hp_in[c];
          hp_prev_y[c] <= sat(hp_y);
        end
      end
    end
  endgenerate

  // Per-channel mixer sums
  wire [7:0] side_att [3];
  assign side_att[0] = sidetone_ch12[7:0];
  assign side_att[1] = sidetone_ch12[15:8];
  assign side_att[2] = sidetone_ch3[7:0];
  wire signed [15:0] mix_out [3];
  generate
    for (genvar c = 0; c < 3; c++) begin : g_mix
      wire signed [17:0] s = 18'(sig[mix_sel[c][4:0]]) + 18'(sig[mix_sel[c][9:5]])
                            + 18'(scale8(sig[mix_sel[c][14:10]], side_att[c]));
      assign mix_out[c] = sat(s);
    end
  endgenerate

  // Gain stage pre-sum, second input attenuated
  wire signed [17:0] agc_sum_w = 18'(sig[agc_cfg[4:0]]) + 18'(scale15(sig[agc_cfg[9:5]], agc_inatt[14:0]));
  assign agc_sum = sat(agc_sum_w);
  wire [15:0] agc_mag = agc_sum[15] ? 16'(-agc_sum) : agc_sum;
  wire agc_regulate = agc_peak[15:8] > $signed({1'b0, agc_peak_cfg[14:8]});
  wire agc_loud = agc_peak[15:8] > $signed({1'b0, agc_init_cmp[14:8]});
  wire signed [15:0] gain_hi = 16'(sigpath_pkg::AGC_UNITY) + 16'(agc_ranges[15:8]);
  wire signed [15:0] gain_lo = 16'(sigpath_pkg::AGC_UNITY) - 16'(agc_ranges[6:0]);
  wire signed [23:0] agc_prod = agc_sum * agc_gain;

  // Equalizer coefficient addressing
  wire [5:0] eq_adr = eq_ctrl[10:5];
  wire eq_adr_ok = eq_adr <= sigpath_pkg::EQ_LAST;
  wire sel_eq_coef = address == sigpath_pkg::ADDR_EQ_COEF;
  wire sel_peak_val = address == sigpath_pkg::ADDR_PEAK_VALUE;
  wire bus_take = (read | write) && bus_state == BUS_IDLE;
  wire peak_en = peak_ctrl[sigpath_pkg::BIT_EN];
  wire peak_min = peak_ctrl[sigpath_pkg::BIT_MM];
  wire signed [15:0] peak_in = sig[peak_ctrl[4:0]];
  assign wdat = writedata[15:0];
  wire known = address <= sigpath_pkg::ADDR_LINK_MODE && address[1:0] == 2'b00;

  // Equalizer data path, IIR then FIR
  logic signed [39:0] iir_acc, fir_acc;
  always_comb begin
    iir_acc = 40'sd0;
    for (int i = 0; i < 9; i++)
      iir_acc = iir_acc + 40'(eq_iir_x[i] * $signed(eq_coef[i]));
    for (int i = 0; i < 8; i++)
      iir_acc = iir_acc - 40'(eq_iir_y[i] * $signed(eq_coef[9 + i]));
    fir_acc = 40'sd0;
    for (int i = 0; i < 17; i++)
      fir_acc = fir_acc + 40'(eq_fir[i] * $signed(eq_coef[18 + i]));
  end
  wire signed [39:0] iir_sc = (iir_acc >>> 14) * $signed(eq_coef[17]);
  wire signed [39:0] fir_sc = (fir_acc >>> 14) * $signed(eq_coef[35]);
  assign eq_iir_out = sat(18'(iir_sc >>> 14));
  assign eq_fir_out = sat(18'(fir_sc >>> 14));

  // Read mux
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (address)
      sigpath_pkg::ADDR_MIX_CH1: next_readdata[15:0] = mix_sel[0];
      sigpath_pkg::ADDR_MIX_CH2: next_readdata[15:0] = mix_sel[1];
      sigpath_pkg::ADDR_MIX_CH3: next_readdata[15:0] = mix_sel[2];
      sigpath_pkg::ADDR_SIDETONE_CH12: next_readdata[15:0] = sidetone_ch12;
      sigpath_pkg::ADDR_SIDETONE_CH3: next_readdata[15:0] = sidetone_ch3;
      sigpath_pkg::ADDR_UNIV_ATTEN: next_readdata[15:0] = univ_ctrl;
      sigpath_pkg::ADDR_AGC_CONFIG: next_readdata[15:0] = agc_cfg;
      sigpath_pkg::ADDR_AGC_INATT: next_readdata[15:0] = agc_inatt;
      sigpath_pkg::ADDR_AGC_INIT_CMP: next_readdata[15:0] = agc_init_cmp;
      sigpath_pkg::ADDR_AGC_RATES: next_readdata[15:0] = agc_rates;
      sigpath_pkg::ADDR_AGC_RANGES: next_readdata[15:0] = agc_ranges;
      sigpath_pkg::ADDR_AGC_PEAK: next_readdata[15:0] = agc_peak_cfg;
      sigpath_pkg::ADDR_AGC_LOWPASS: next_readdata[15:0] = agc_lowpass;
      sigpath_pkg::ADDR_EQ_CTRL: next_readdata[15:0] = eq_ctrl;
      sigpath_pkg::ADDR_EQ_COEF: next_readdata[15:0] = eq_adr_ok ? eq_coef[eq_adr] : 16'h0000;
      sigpath_pkg::ADDR_PEAK_CTRL: next_readdata[15:0] = peak_ctrl;
      sigpath_pkg::ADDR_PEAK_VALUE: next_readdata[15:0] = peak_value;
      sigpath_pkg::ADDR_LINK_MODE: next_readdata[15:0] = link_mode;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // Bus handshake: one wait cycle, answer with waitrequest low
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_state <= BUS_IDLE;
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
      response <= 2'b00;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          waitrequest <= 1'b1;
          if (read | write) begin
            bus_state <= BUS_ANSWER;
            waitrequest <= 1'b0;
            readdata <= read ? next_readdata : 32'h0000_0000;
            response <= known ? 2'b00 : 2'b11;
          end
        end
        BUS_ANSWER: begin
          bus_state <= BUS_IDLE;
          waitrequest <= 1'b1;
        end
        default: bus_state <= BUS_IDLE;
      endcase
    end
  end

  // Register writes; index advances on data access
  wire wr = bus_take & write & (&byteenable[1:0]);
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 3; i++)
        mix_sel[i] <= sigpath_pkg::HP_RESET;
      sidetone_ch12 <= sigpath_pkg::REG_RESET;
      sidetone_ch3 <= sigpath_pkg::REG_RESET;
      univ_ctrl <= sigpath_pkg::REG_RESET;
      agc_cfg <= sigpath_pkg::REG_RESET;
      agc_inatt <= sigpath_pkg::REG_RESET;
      agc_init_cmp <= sigpath_pkg::REG_RESET;
      agc_rates <= sigpath_pkg::REG_RESET;
      agc_ranges <= sigpath_pkg::REG_RESET;
      agc_peak_cfg <= sigpath_pkg::REG_RESET;
      agc_lowpass <= sigpath_pkg::REG_RESET;
      eq_ctrl <= sigpath_pkg::REG_RESET;
      peak_ctrl <= sigpath_pkg::REG_RESET;
      link_mode <= sigpath_pkg::REG_RESET;
    end else begin
      if (wr) begin
        case (address)
          sigpath_pkg::ADDR_MIX_CH1: mix_sel[0] <= wdat;
          sigpath_pkg::ADDR_MIX_CH2: mix_sel[1] <= wdat;
          sigpath_pkg::ADDR_MIX_CH3: mix_sel[2] <= wdat;
          sigpath_pkg::ADDR_SIDETONE_CH12: sidetone_ch12 <= wdat;
          sigpath_pkg::ADDR_SIDETONE_CH3: sidetone_ch3 <= wdat;
          sigpath_pkg::ADDR_UNIV_ATTEN: univ_ctrl <= wdat;
          sigpath_pkg::ADDR_AGC_CONFIG: agc_cfg <= wdat;
          sigpath_pkg::ADDR_AGC_INATT: agc_inatt <= wdat;
          sigpath_pkg::ADDR_AGC_INIT_CMP: agc_init_cmp <= wdat;
          sigpath_pkg::ADDR_AGC_RATES: agc_rates <= wdat;
          sigpath_pkg::ADDR_AGC_RANGES: agc_ranges <= wdat;
          sigpath_pkg::ADDR_AGC_PEAK: agc_peak_cfg <= wdat;
          sigpath_pkg::ADDR_AGC_LOWPASS: agc_lowpass <= wdat;
          sigpath_pkg::ADDR_EQ_CTRL: eq_ctrl <= wdat;
          sigpath_pkg::ADDR_PEAK_CTRL: peak_ctrl <= wdat;
          sigpath_pkg::ADDR_LINK_MODE: link_mode <= wdat;
          default: ;
        endcase
      end
      if (bus_take && sel_eq_coef)
        eq_ctrl[10:5] <= eq_adr_ok ? 6'(eq_adr + 6'd1) : 6'd0;
    end
  end

  // Coefficient store written through the data register
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < EQ_COEFS_L; i++)
        eq_coef[i] <= 16'h0000;
    end else if (wr && sel_eq_coef && eq_adr_ok) begin
      eq_coef[eq_adr] <= wdat;
    end
  end

  // Peak monitor; read and enable reload start value
  always_ff @(posedge clk) begin
    if (reset) begin
      peak_en_d <= 1'b0;
      peak_value <= sigpath_pkg::PEAK_MOST_NEG;
    end else begin
      peak_en_d <= peak_en;
      if ((peak_en & ~peak_en_d) || (bus_take && read && sel_peak_val))
        peak_value <= peak_min ? sigpath_pkg::PEAK_MOST_POS : sigpath_pkg::PEAK_MOST_NEG;
      else if (peak_en && sample_strobe) begin
        if (!peak_min && peak_in > $signed(peak_value))
          peak_value <= peak_in;
        else if (peak_min && peak_in < $signed(peak_value))
          peak_value <= peak_in;
      end
    end
  end

  // Sample-rate units: mixers, attenuator, gain stage, equalizer
  always_ff @(posedge clk) begin
    if (reset) begin
      to_ch1 <= 16'h0000;
      to_ch2 <= 16'h0000;
      to_ch3 <= 16'h0000;
      to_ch2_slot1 <= 8'h00;
      universal_atten_out <= 16'h0000;
      gain_stage_out <= 16'h0000;
      gain_stage_sum_out <= 16'h0000;
      equalizer_out <= 16'h0000;
      out_valid <= 1'b0;
      agc_peak <= 16'sh0000;
      agc_gain <= 16'sh0080;
      for (int i = 0; i < 9; i++)
        eq_iir_x[i] <= 16'sh0000;
      for (int i = 0; i < 8; i++)
        eq_iir_y[i] <= 16'sh0000;
      for (int i = 0; i < 17; i++)
        eq_fir[i] <= 16'sh0000;
    end else begin
      out_valid <= sample_strobe;
      if (sample_strobe) begin
        to_ch1 <= mix_out[0];
        // Split mode: two companded slots in place of linear word
        if (link_mode[sigpath_pkg::BIT_SIMPLE])
          to_ch2 <= 16'h0000;
        else if (link_mode[sigpath_pkg::BIT_SPLIT]) begin
          to_ch2 <= {compand(mix_out[1], link_mode[sigpath_pkg::BIT_MULAW0]), 8'h00};
          to_ch2_slot1 <= compand(mix_out[2], link_mode[sigpath_pkg::BIT_MULAW1]);
        end else
          to_ch2 <= mix_out[1];
        to_ch3 <= link_mode[sigpath_pkg::BIT_SIMPLE] ? 16'h0000 : mix_out[2];
        universal_atten_out <= scale8(sig[univ_ctrl[12:8]], univ_ctrl[7:0]);
        gain_stage_sum_out <= agc_sum;
        // Peak tracker: capture new maximum, else decay
        if ($signed({1'b0, agc_mag[15:1]}) > agc_peak)
          agc_peak <= $signed({1'b0, agc_mag[15:1]});
        else
          agc_peak <= agc_peak - (agc_peak >>> agc_peak_cfg[2:0]) - 16'(agc_peak_cfg[6:3] != 4'h0);
        if (!agc_cfg[sigpath_pkg::BIT_EN]) begin
          agc_gain <= 16'(agc_init_cmp[7:0]);
          gain_stage_out <= 16'h0000;
        end else begin
          if (agc_regulate) begin
            if (agc_loud && agc_gain > gain_lo)
              agc_gain <= agc_gain - 16'(agc_rates[15:8] != 8'h00);
            else if (!agc_loud && agc_gain < gain_hi)
              agc_gain <= agc_gain + 16'(agc_rates[7:0] != 8'h00);
          end
          gain_stage_out <= sat(18'(agc_prod >>> 7));
        end
        if (eq_ctrl[sigpath_pkg::BIT_EN]) begin
          eq_iir_x[0] <= sig[eq_ctrl[4:0]];
          for (int i = 1; i < 9; i++)
            eq_iir_x[i] <= eq_iir_x[i - 1];
          eq_iir_y[0] <= eq_iir_out;
          for (int i = 1; i < 8; i++)
            eq_iir_y[i] <= eq_iir_y[i - 1];
          eq_fir[0] <= eq_iir_out;
          for (int i = 1; i < 17; i++)
            eq_fir[i] <= eq_fir[i - 1];
          equalizer_out <= eq_fir_out;
        end else
          equalizer_out <= sig[eq_ctrl[4:0]];
      end
    end
  end
endmodule
`default_nettype wire

// ### sigpath_pkg.sv
// Constants for the sample-domain signal path units
`default_nettype none
package sigpath_pkg;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned SIG_COUNT = 32;
  // Register byte addresses
  localparam logic [6:0] ADDR_MIX_CH1 = 7'h00;
  localparam logic [6:0] ADDR_MIX_CH2 = 7'h04;
  localparam logic [6:0] ADDR_MIX_CH3 = 7'h08;
  localparam logic [6:0] ADDR_SIDETONE_CH12 = 7'h0c;
  localparam logic [6:0] ADDR_SIDETONE_CH3 = 7'h10;
  localparam logic [6:0] ADDR_UNIV_ATTEN = 7'h14;
  localparam logic [6:0] ADDR_AGC_CONFIG = 7'h18;
  localparam logic [6:0] ADDR_AGC_INATT = 7'h1c;
  localparam logic [6:0] ADDR_AGC_INIT_CMP = 7'h20;
  localparam logic [6:0] ADDR_AGC_RATES = 7'h24;
  localparam logic [6:0] ADDR_AGC_RANGES = 7'h28;
  localparam logic [6:0] ADDR_AGC_PEAK = 7'h2c;
  localparam logic [6:0] ADDR_AGC_LOWPASS = 7'h30;
  localparam logic [6:0] ADDR_EQ_CTRL = 7'h34;
  localparam logic [6:0] ADDR_EQ_COEF = 7'h38;
  localparam logic [6:0] ADDR_PEAK_CTRL = 7'h3c;
  localparam logic [6:0] ADDR_PEAK_VALUE = 7'h40;
  localparam logic [6:0] ADDR_LINK_MODE = 7'h44;
  // Mixer select layout: first [4:0], second [9:5], third [14:10], highpass [15]
  localparam int unsigned FLD_FIRST = 0;
  localparam int unsigned FLD_SECOND = 5;
  localparam int unsigned FLD_THIRD = 10;
  localparam int unsigned BIT_HP = 15;
  // Enable bit shared by control registers, fields below it
  localparam int unsigned BIT_EN = 15;
  localparam int unsigned FLD_EQ_SRC = 0;
  localparam int unsigned FLD_EQ_ADR = 5;
  localparam int unsigned BIT_MM = 5;
  localparam int unsigned FLD_ATT_SRC = 8;
  // Link mode: [0] simple serial, [1] ch2 split, [2] slot0 mu-law, [3] slot1 mu-law
  localparam int unsigned BIT_SIMPLE = 0;
  localparam int unsigned BIT_SPLIT = 1;
  localparam int unsigned BIT_MULAW0 = 2;
  localparam int unsigned BIT_MULAW1 = 3;
  // Equalizer coefficient store: 9 ff, 8 fb, iir scale, 17 taps, fir scale
  localparam int unsigned EQ_FF = 9;
  localparam int unsigned EQ_FB = 8;
  localparam int unsigned EQ_TAPS = 17;
  localparam int unsigned EQ_COEFS = 36;
  localparam logic [5:0] EQ_LAST = 6'd35;
  localparam logic [15:0] PEAK_MOST_NEG = 16'h8000;
  localparam logic [15:0] PEAK_MOST_POS = 16'h7fff;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] HP_RESET = 16'h8000;
  localparam logic [7:0] AGC_UNITY = 8'h80;
endpackage
`default_nettype wire

// ### sigpath_checker.sv
// Port-level checks for the signal path units
`default_nettype none
module sigpath_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register bus
  input wire logic [6:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  // Sample stream
  input wire logic sample_strobe,
  input wire logic out_valid,
  input wire logic [15:0] to_ch1,
  input wire logic [15:0] equalizer_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Bus answer timing and codes
  ack_one_cycle_a: assert property (!waitrequest |=> waitrequest) else $error("ack too long");
  ack_cause_a: assert property (!waitrequest |-> read || write) else $error("ack without request");
  ack_prompt_a: assert property ($rose(read) || $rose(write) |=> !waitrequest) else $error("late ack");
  unmapped_resp_a: assert property (!waitrequest && read && address > 7'h44 |-> response == 2'b11 && readdata == 32'h0)
    else $error("unmapped answer wrong");
  mapped_ok_a: assert property (!waitrequest && address <= 7'h44 |-> response == 2'b00) else $error("bad response");
  rd_hold_a: assert property (waitrequest |-> $stable(readdata)) else $error("readdata moved");
  // Stream timing
  strobe_valid_a: assert property (sample_strobe |=> out_valid) else $error("no out_valid");
  valid_cause_a: assert property (out_valid |-> $past(sample_strobe)) else $error("stray out_valid");
  out_stand_a: assert property (!out_valid |-> $stable(to_ch1) && $stable(equalizer_out))
    else $error("output moved");
  reset_idle_a: assert property ($fell(reset) |-> waitrequest && !out_valid) else $error("not idle");
endmodule
`default_nettype wire

// ### sigpath_stream_src.sv
// Far-side sample source for the serial channels and analog input
`default_nettype none
module sigpath_stream_src (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control from the bench
  input wire logic run,
  input wire logic [15:0] level,
  // Sample stream
  output logic sample_strobe,
  output logic [15:0] from_ch1,
  output logic [15:0] from_ch2,
  output logic [15:0] from_ch3,
  output logic [15:0] from_analog
);
  logic [1:0] phase;
  // Phase counter, one strobe every fourth cycle while running
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  // Idle lines show the inverse, never a stale sample
  assign sample_strobe = run && (phase == 2'h3);
  assign from_analog = run ? level : ~level;
  assign from_ch1 = run ? level : ~level;
  assign from_ch2 = ~from_ch1;
  assign from_ch3 = from_ch1 ^ 16'h5a5a;
endmodule
`default_nettype wire

// ### signal_path_conditioning_units_tb_top.sv
// Self-checking bench for the signal path units
`default_nettype none
module signal_path_conditioning_units_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [6:0] address = 7'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, sample_strobe, out_valid;
  logic [1:0] response, rsp;
  logic [15:0] from_ch1, from_ch2, from_ch3, from_analog, to_ch1, equalizer_out;
  logic [15:0] to_ch3, universal_atten_out, gain_stage_out, gain_stage_sum_out;
  logic run = 1'b0;
  logic [15:0] level = 16'h0;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  // Design and sample source
  signal_path_conditioning_units signal_path_conditioning_units_inst (.clk, .reset, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .response, .sample_strobe, .from_ch1, .from_ch2, .from_ch3,
    .from_analog, .to_ch1, .to_ch2(), .to_ch3, .to_ch2_slot1(), .universal_atten_out, .gain_stage_out,
    .gain_stage_sum_out, .equalizer_out, .out_valid);
  sigpath_stream_src sigpath_stream_src_inst (.clk, .reset, .run, .level, .sample_strobe, .from_ch1, .from_ch2,
    .from_ch3, .from_analog);
  // Clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Verdict and end of run
  task automatic end_of_test();
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [6:0] a, input logic [15:0] d, input logic [3:0] b);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {16'h0, d};
    byteenable <= b;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    rsp = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Register read with expected value
  task automatic rdc(input string what, input logic [6:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0, 4'hf);
    chk(what, rd, {16'h0, e});
  endtask
  // Run the sample stream at one level
  task automatic feed(input logic [15:0] v);
    @(posedge clk);
    level <= v;
    run <= 1'b1;
    repeat (20) @(posedge clk);
    run <= 1'b0;
    @(posedge clk); // Outputs of the last strobe settle
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rdc("mix reset", 7'(4 * i), sigpath_pkg::HP_RESET);
    end
    rdc("eq ctrl reset", sigpath_pkg::ADDR_EQ_CTRL, sigpath_pkg::REG_RESET);
    acc(1'b1, sigpath_pkg::ADDR_UNIV_ATTEN, 16'h1234, 4'hf);
    acc(1'b1, sigpath_pkg::ADDR_UNIV_ATTEN, 16'h0055, 4'h0);
    rdc("univ atten", sigpath_pkg::ADDR_UNIV_ATTEN, 16'h1234);
    acc(1'b0, 7'h48, 16'h0, 4'hf);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped resp", 32'(rsp), 32'h3);
    // Coefficient index walks past the end and wraps
    acc(1'b1, sigpath_pkg::ADDR_EQ_CTRL, 16'h0440, 4'hf);
    acc(1'b1, sigpath_pkg::ADDR_EQ_COEF, 16'h1111, 4'hf);
    acc(1'b1, sigpath_pkg::ADDR_EQ_COEF, 16'h2222, 4'hf);
    rdc("eq index end", sigpath_pkg::ADDR_EQ_CTRL, 16'h0480);
    acc(1'b1, sigpath_pkg::ADDR_EQ_COEF, 16'h3333, 4'hf);
    rdc("eq index wrap", sigpath_pkg::ADDR_EQ_CTRL, 16'h0000);
    acc(1'b1, sigpath_pkg::ADDR_EQ_CTRL, 16'h0440, 4'hf);
    rdc("eq coef 34", sigpath_pkg::ADDR_EQ_COEF, 16'h1111);
    rdc("eq coef 35", sigpath_pkg::ADDR_EQ_COEF, 16'h2222);
    // Mixer sums, side units and peak monitor in both modes
    acc(1'b1, sigpath_pkg::ADDR_MIX_CH1, 16'h0084, 4'hf);
    acc(1'b1, sigpath_pkg::ADDR_MIX_CH3, 16'h0084, 4'hf);
    acc(1'b1, sigpath_pkg::ADDR_UNIV_ATTEN, 16'h0480, 4'hf);
    acc(1'b1, sigpath_pkg::ADDR_AGC_CONFIG, 16'h0084, 4'hf);
    acc(1'b1, sigpath_pkg::ADDR_AGC_INATT, 16'h4000, 4'hf);
    acc(1'b1, sigpath_pkg::ADDR_EQ_CTRL, 16'h0004, 4'hf);
    acc(1'b1, sigpath_pkg::ADDR_PEAK_CTRL, 16'h8004, 4'hf);
    feed(16'h1234);
    feed(16'h0100);
    chk("mixer sum", 32'(to_ch1), 32'h0200);
    chk("mixer ch3", 32'(to_ch3), 32'h0200);
    chk("univ atten out", 32'(universal_atten_out), 32'h0080);
    chk("gain pre-sum", 32'(gain_stage_sum_out), 32'h0180);
    chk("gain stage off", 32'(gain_stage_out), 32'h0000);
    chk("eq bypass", 32'(equalizer_out), 32'h0100);
    rdc("peak max", sigpath_pkg::ADDR_PEAK_VALUE, 16'h1234);
    rdc("peak max reload", sigpath_pkg::ADDR_PEAK_VALUE, sigpath_pkg::PEAK_MOST_NEG);
    acc(1'b1, sigpath_pkg::ADDR_PEAK_CTRL, 16'h0004, 4'hf);
    acc(1'b1, sigpath_pkg::ADDR_PEAK_CTRL, 16'h8024, 4'hf);
    feed(16'h0100);
    feed(16'hff00);
    rdc("peak min", sigpath_pkg::ADDR_PEAK_VALUE, 16'hff00);
    rdc("peak min reload", sigpath_pkg::ADDR_PEAK_VALUE, sigpath_pkg::PEAK_MOST_POS);
    acc(1'b1, sigpath_pkg::ADDR_PEAK_CTRL, 16'h0024, 4'hf);
    // Simple serial mode keeps only the first channel
    acc(1'b1, sigpath_pkg::ADDR_LINK_MODE, 16'h0001, 4'hf);
    feed(16'h0100);
    chk("simple ch3 off", 32'(to_ch3), 32'h0000);
    chk("simple ch1 on", 32'(to_ch1), 32'h0200);
    end_of_test();
  end
endmodule
bind signal_path_conditioning_units sigpath_checker sigpath_checker_inst (.clk, .reset, .address, .read, .write,
  .readdata, .waitrequest, .response, .sample_strobe, .out_valid, .to_ch1, .equalizer_out);
`default_nettype wire
